// ===== logic/serial_sram_auto_save_control.sv
// Purpose: two-wire slave for a byte-wide sram with a hidden backup array
// Assumes: bus lines, select pins, protect pin and trip level are async pins
// Notes:   only the core clock is used; the bus clock is sampled, not a clock
`timescale 1ns/1ps
// Behaviour
// - answer only when select bits match pins
// - data changes with clock high mean start/stop
// - reject bus glitches up to 50 ns
// - protect input high blocks top-quarter writes
// - protected writes still acknowledge every byte
// - protect input never affects reads
// - floating protect input counts as low
// - one sram visible, backup never reachable
// - trip fall starts automatic save
// - save only when array modified
// - save locks bus for save plus reload
// - supply back during save: finish, reload
// - trip rise starts reload, bus locked meanwhile
// - no control byte acknowledge while busy
// - control byte: opcode, selects, one, read/write
// - supply lost in reload: abort, skip save
module serial_sram_auto_save_control
	import sram_save_pkg::*;
#(
	parameter int         SAVE_CYC    = sram_save_pkg::SAVE_DURATION_CYC,
	parameter int         RELOAD_CYC  = sram_save_pkg::RELOAD_DURATION_CYC,
	parameter logic [3:0] CTRL_OPCODE = sram_save_pkg::CTRL_OPCODE_DEF
) (
	// clock and reset
	input  wire logic clock_i,
	input  wire logic arst_n_i,
	// two-wire bus, data line is open drain
	input  wire logic scl_i,
	input  wire logic sda_i,
	output logic      sda_o,
	output logic      sda_oe_o,
	// straps and protect
	input  wire logic chip_sel_pin_low_i,
	input  wire logic chip_sel_pin_high_i,
	input  wire logic write_protect_i,
	// backup_cap_supply above the trip threshold
	input  wire logic cap_above_trip_i,
	// status
	output logic      busy_o,
	output logic      modified_o
);
	import sram_save_pkg::*;

	// ------------------------------------------------------------
	// pin conditioning
	// ------------------------------------------------------------
	logic [5:0] pins_raw;  // {trip, protect, sel high, sel low, sda, scl}
	logic [5:0] pins_flt;  // synchronised and filtered
	logic       scl_f;     // filtered bus clock
	logic       sda_f;     // filtered bus data
	logic       scl_q;     // previous filtered bus clock
	logic       sda_q;     // previous filtered bus data
	logic       wp_f;      // protect level
	logic       trip_f;    // supply above trip
	logic [1:0] sel_pins;  // {high, low} strap levels

	assign pins_raw = {cap_above_trip_i, write_protect_i, chip_sel_pin_high_i,
		chip_sel_pin_low_i, sda_i, scl_i};

	// bus lines get the glitch filter, slow pins only the synchroniser
	for (genvar i = 0; i < 6; i++) begin : g_pin
		pin_filter #(
			.STABLE_CYC (i < 2 ? SPIKE_FILTER_CYC : 0),
			.INIT       (i < 2 ? 1'h1 : 1'h0)
		) u_flt (
			.clock_i  (clock_i),
			.arst_n_i (arst_n_i),
			.pin_i    (pins_raw[i]),
			.level_o  (pins_flt[i])
		);
	end

	assign scl_f    = pins_flt[0];
	assign sda_f    = pins_flt[1];
	assign sel_pins = pins_flt[3:2];
	// a floating protect pin is pulled low at the pad, so only a driven
	// high reaches here as one and the whole array stays writable
	assign wp_f     = pins_flt[4];
	assign trip_f   = pins_flt[5];

	// previous filtered levels for edge and condition detection
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			scl_q <= 1'h1;
			sda_q <= 1'h1;
		end else begin
			scl_q <= scl_f;
			sda_q <= sda_f;
		end
	end

	logic scl_rise;   // bus clock rising
	logic scl_fall;   // bus clock falling
	logic start_seen; // data falls with clock high
	logic stop_seen;  // data rises with clock high

	assign scl_rise   = scl_f & ~scl_q;
	assign scl_fall   = ~scl_f & scl_q;
	assign start_seen = scl_f & scl_q & sda_q & ~sda_f;
	assign stop_seen  = scl_f & scl_q & ~sda_q & sda_f;

	// ------------------------------------------------------------
	// arrays: only the working sram is reachable from the bus
	// ------------------------------------------------------------
	logic [DATA_W-1:0] sram   [ARRAY_DEPTH]; // working array
	logic [DATA_W-1:0] backup [ARRAY_DEPTH]; // hidden copy, no bus path
	logic [ADDR_W-1:0] addr;                 // bus address pointer
	logic [DATA_W-1:0] rd_byte;              // byte under the pointer

	assign rd_byte = sram[addr];

	// ------------------------------------------------------------
	// power sequencing
	// ------------------------------------------------------------
	pwr_state_t          pwr;       // power phase
	logic [OP_CNT_W-1:0] op_cnt;    // elapsed cycles of save or reload
	logic [ADDR_W-1:0]   copy_idx;  // byte being moved between arrays
	logic                copy_done; // whole array moved
	logic                op_done;   // duration and copy both complete
	logic                modified;  // written since last save or reload

	assign op_done = copy_done && (pwr == P_SAVE
		? op_cnt >= OP_CNT_W'(SAVE_CYC - 1)
		: op_cnt >= OP_CNT_W'(RELOAD_CYC - 1));
	// the bus is shut whenever the array is not plainly ready
	assign busy_o     = pwr != P_READY;
	assign modified_o = modified;

	// phase transitions; counters restart on every new operation
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pwr       <= P_DOWN;
			op_cnt    <= '0;
			copy_idx  <= '0;
			copy_done <= 1'h0;
		end else begin
			case (pwr)
				P_DOWN: begin
					if (trip_f) begin
						pwr       <= P_RELOAD;
						op_cnt    <= '0;
						copy_idx  <= '0;
						copy_done <= 1'h0;
					end
				end
				P_RELOAD: begin
					if (!trip_f) begin
						// aborted reload leaves nothing to save
						pwr <= P_DOWN;
					end else if (op_done) begin
						pwr <= P_READY;
					end else begin
						op_cnt <= op_cnt + 1'b1;
					end
				end
				P_READY: begin
					if (!trip_f) begin
						// an untouched array skips the wear of a save
						pwr       <= modified ? P_SAVE : P_DOWN;
						op_cnt    <= '0;
						copy_idx  <= '0;
						copy_done <= 1'h0;
					end
				end
				P_SAVE: begin
					// the save runs to its end whatever the supply does
					if (op_done) begin
						if (trip_f) begin
							pwr       <= P_RELOAD;
							op_cnt    <= '0;
							copy_idx  <= '0;
							copy_done <= 1'h0;
						end else begin
							pwr <= P_DOWN;
						end
					end else begin
						op_cnt <= op_cnt + 1'b1;
					end
				end
				default: pwr <= P_DOWN;
			endcase
			// one byte per cycle; duration covers the whole array
			if ((pwr == P_SAVE || pwr == P_RELOAD) && !copy_done) begin
				copy_idx  <= copy_idx + 1'b1;
				copy_done <= copy_idx == ADDR_W'(ARRAY_DEPTH - 1);
			end
		end
	end

	// ------------------------------------------------------------
	// bus slave
	// ------------------------------------------------------------
	bus_state_t  st;      // bit-level state
	phase_t      phase;   // which received byte comes next
	logic [7:0]  shift;   // received bits, msb first
	logic [3:0]  bit_cnt; // bits moved in this byte
	logic [7:0]  tx_byte; // remaining bits to send
	logic        rd_mode; // addressed for read
	logic        mack;    // master acknowledged last byte
	ctrl_byte_t  ctrl;    // received byte seen as control byte
	logic        ctrl_hit;
	logic        byte_in; // eighth bit complete on a falling edge
	logic        prot_hit;
	logic        bus_we;  // commit a data byte to the array

	assign ctrl     = ctrl_byte_t'(shift);
	assign ctrl_hit = ctrl.opcode == CTRL_OPCODE && ctrl.sel == sel_pins
		&& ctrl.fixed == CTRL_FIXED_SEL;
	assign byte_in  = scl_fall && st == ST_RX && bit_cnt == BIT_CNT_FULL;
	assign prot_hit = wp_f && addr[ADDR_W-1 -: 2] == PROT_TOP_BITS;
	assign bus_we   = pwr == P_READY && byte_in && phase == PH_DATA && !prot_hit;
	assign sda_o    = 1'h0; // open drain: only ever pulls low

	// working array: reload copy or committed bus write
	always_ff @(posedge clock_i) begin
		if (pwr == P_RELOAD && trip_f && !copy_done) begin
			sram[copy_idx] <= backup[copy_idx];
		end else if (bus_we) begin
			sram[addr] <= shift;
		end
	end

	// hidden array is only written by the save
	always_ff @(posedge clock_i) begin
		if (pwr == P_SAVE && !copy_done) begin
			backup[copy_idx] <= sram[copy_idx];
		end
	end

	// modified flag: a write wins over a clear in the same cycle
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			modified <= 1'h0;
		end else if (bus_we) begin
			modified <= 1'h1;
		end else if (op_done && (pwr == P_SAVE || pwr == P_RELOAD)) begin
			modified <= 1'h0;
		end
	end

	// bit engine; busy drops any transfer and releases the line
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st       <= ST_IDLE;
			phase    <= PH_CTRL;
			shift    <= 8'h00;
			bit_cnt  <= 4'h0;
			tx_byte  <= 8'h00;
			rd_mode  <= 1'h0;
			mack     <= 1'h0;
			addr     <= '0;
			sda_oe_o <= 1'h0;
		end else if (pwr != P_READY) begin
			st       <= ST_IDLE;
			sda_oe_o <= 1'h0;
		end else if (start_seen) begin
			// repeated start keeps the pointer for random reads
			st       <= ST_RX;
			phase    <= PH_CTRL;
			bit_cnt  <= 4'h0;
			sda_oe_o <= 1'h0;
		end else if (stop_seen) begin
			st       <= ST_IDLE;
			sda_oe_o <= 1'h0;
		end else if (scl_rise) begin
			// sample while the clock is high
			if (st == ST_RX) begin
				shift   <= {shift[6:0], sda_f};
				bit_cnt <= bit_cnt + 4'h1;
			end else if (st == ST_TX_ACK) begin
				mack <= ~sda_f;
			end
		end else if (scl_fall) begin
			// drive only while the clock is low
			case (st)
				ST_RX: begin
					if (bit_cnt == BIT_CNT_FULL) begin
						if (phase != PH_CTRL || ctrl_hit) begin
							st       <= ST_RX_ACK;
							sda_oe_o <= 1'h1;
						end else begin
							st <= ST_IDLE;
						end
						case (phase)
							PH_CTRL: begin
								rd_mode <= ctrl.rd;
								phase   <= PH_AHI;
							end
							PH_AHI: begin
								addr[ADDR_W-1:DATA_W] <= shift[ADDR_HI_W-1:0];
								phase                 <= PH_ALO;
							end
							PH_ALO: begin
								addr[DATA_W-1:0] <= shift;
								phase            <= PH_DATA;
							end
							default: begin
								// pointer moves on whether stored or not
								addr <= addr + 1'b1;
							end
						endcase
					end
				end
				ST_RX_ACK: begin
					if (rd_mode) begin
						// reads ignore the protect input entirely
						st       <= ST_TX;
						tx_byte  <= {rd_byte[6:0], 1'h0};
						sda_oe_o <= ~rd_byte[7];
						addr     <= addr + 1'b1;
						bit_cnt  <= 4'h1;
					end else begin
						st       <= ST_RX;
						sda_oe_o <= 1'h0;
						bit_cnt  <= 4'h0;
					end
				end
				ST_TX: begin
					if (bit_cnt == BIT_CNT_FULL) begin
						st       <= ST_TX_ACK;
						sda_oe_o <= 1'h0;
					end else begin
						sda_oe_o <= ~tx_byte[7];
						tx_byte  <= {tx_byte[6:0], 1'h0};
						bit_cnt  <= bit_cnt + 4'h1;
					end
				end
				ST_TX_ACK: begin
					if (mack) begin
						st       <= ST_TX;
						tx_byte  <= {rd_byte[6:0], 1'h0};
						sda_oe_o <= ~rd_byte[7];
						addr     <= addr + 1'b1;
						bit_cnt  <= 4'h1;
					end else begin
						// no acknowledge ends the read, line left high
						st <= ST_IDLE;
					end
				end
				default: sda_oe_o <= 1'h0;
			endcase
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!arst_n_i);

	// the protected byte keeps its old contents, whatever the flag does
	a_protect_no_write: assert property (
		(pwr == P_READY && byte_in && phase == PH_DATA && wp_f
		&& addr[ADDR_W-1 -: 2] == PROT_TOP_BITS)
		|=> sram[$past(addr)] == $past(sram[addr]))
		else $error("write into protected quarter was committed");
	a_protect_still_ack: assert property (
		(pwr == P_READY && byte_in && phase == PH_DATA && prot_hit)
		|=> sda_oe_o && st == ST_RX_ACK)
		else $error("protected data byte was not acknowledged");
	a_select_mismatch: assert property (
		(pwr == P_READY && trip_f && byte_in && phase == PH_CTRL && ctrl.sel != sel_pins)
		|=> !sda_oe_o ##1 !sda_oe_o)
		else $error("acknowledged a control byte for another select");
	a_busy_no_ack: assert property (
		busy_o |=> !sda_oe_o)
		else $error("line pulled low while busy");
	a_save_when_mod: assert property (
		(pwr == P_READY && !trip_f && modified) |=> pwr == P_SAVE)
		else $error("save did not start on trip fall");
	a_skip_clean_save: assert property (
		(pwr == P_READY && !trip_f && !modified) |=> pwr == P_DOWN)
		else $error("save started on an unmodified array");
	a_save_lockout: assert property (
		$rose(pwr == P_SAVE) |-> (pwr == P_SAVE && busy_o)[*8])
		else $error("save ended too early");
	a_reload_after_save: assert property (
		(pwr == P_SAVE && op_done && trip_f) |=> pwr == P_RELOAD ##1 busy_o)
		else $error("no reload after a save with supply back");
	a_reload_abort: assert property (
		(pwr == P_RELOAD && !trip_f) |=> pwr == P_DOWN ##1 pwr != P_SAVE)
		else $error("reload abort led to a save");
	a_mod_flag_set: assert property (
		bus_we |=> modified)
		else $error("write did not mark the array modified");

	c_save_done: cover property (pwr == P_SAVE && op_done);
	c_reload_done: cover property (pwr == P_RELOAD && op_done && trip_f);
	c_protected_ack: cover property (byte_in && phase == PH_DATA && prot_hit);
	c_read_byte: cover property (st == ST_TX_ACK && scl_fall && mack);

endmodule

// ===== logic/sram_save_pkg.sv
// Purpose: shared constants and types for the serial sram save/reload control
// Assumes: core clock of 250 MHz sampling the two-wire bus and all pins
// Notes:   durations keep their printed units; cycle counts derive from them
package sram_save_pkg;

	// ------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS         = 4;
	// glitches up to this width are rejected on both bus lines
	localparam int SPIKE_FILTER_WIDTH_NS = 50;
	// least time, rounded up to whole cycles
	localparam int SPIKE_FILTER_CYC      = (SPIKE_FILTER_WIDTH_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int SAVE_DURATION_MS      = 10;
	// longest time, rounded down
	localparam int SAVE_DURATION_CYC     = SAVE_DURATION_MS * 1000000 / CLK_PERIOD_NS;
	localparam int RELOAD_DURATION_US    = 550;
	localparam int RELOAD_DURATION_CYC   = RELOAD_DURATION_US * 1000 / CLK_PERIOD_NS;
	localparam int OP_CNT_W              = 22;

	// ------------------------------------------------------------
	// array layout
	// ------------------------------------------------------------
	localparam int         ARRAY_DEPTH   = 8192;
	localparam int         ADDR_W        = 13;
	localparam int         DATA_W        = 8;
	localparam int         ADDR_HI_W     = ADDR_W - DATA_W;
	// top quarter: both upper address bits set
	localparam logic [1:0] PROT_TOP_BITS = 2'h3;

	// ------------------------------------------------------------
	// control byte
	// ------------------------------------------------------------
	// opcode value is arbitrary, override per system
	localparam logic [3:0] CTRL_OPCODE_DEF = 4'h0;
	localparam logic       CTRL_FIXED_SEL  = 1'h1;
	localparam logic [3:0] BIT_CNT_FULL    = 4'h8;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef struct packed {
		logic [3:0] opcode; // operation code
		logic [1:0] sel;    // {high, low} chip select
		logic       fixed;  // always one
		logic       rd;     // 1 read, 0 write
	} ctrl_byte_t;

	typedef enum {P_DOWN, P_RELOAD, P_READY, P_SAVE} pwr_state_t;
	typedef enum {ST_IDLE, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK} bus_state_t;
	typedef enum {PH_CTRL, PH_AHI, PH_ALO, PH_DATA} phase_t;

endpackage

// ===== logic/pin_filter.sv
// Purpose: two-flop synchroniser followed by a stability filter for one pin
// Assumes: pin is asynchronous to clock_i
// Notes:   a change passes only after STABLE_CYC+1 equal samples
`timescale 1ns/1ps
module pin_filter #(
	parameter int   STABLE_CYC = 0,
	parameter logic INIT       = 1'h0
) (
	// clock and reset
	input  wire logic clock_i,
	input  wire logic arst_n_i,
	// pin in, clean level out
	input  wire logic pin_i,
	output logic      level_o
);

	logic       sync_a; // first stage, read only by sync_b
	logic       sync_b; // second stage
	logic [7:0] cnt;    // run length of a differing level

	// ------------------------------------------------------------
	// synchroniser
	// ------------------------------------------------------------
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sync_a <= INIT;
			sync_b <= INIT;
		end else begin
			sync_a <= pin_i;
			sync_b <= sync_a;
		end
	end

	// ------------------------------------------------------------
	// filter: pulses of STABLE_CYC samples or fewer never reach level_o
	// ------------------------------------------------------------
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			level_o <= INIT;
			cnt     <= 8'h00;
		end else if (sync_b == level_o) begin
			cnt <= 8'h00;
		end else if (cnt == 8'(STABLE_CYC)) begin
			level_o <= sync_b;
			cnt     <= 8'h00;
		end else begin
			cnt <= cnt + 8'h01;
		end
	end

	a_filter_hold: assert property (@(posedge clock_i) disable iff (!arst_n_i)
		!$stable(level_o) |-> $past(cnt) == 8'(STABLE_CYC))
		else $error("filtered level changed before the stable count");

endmodule

// ===== tb/bus_master_model.sv
// Purpose: behavioural two-wire bus master for the sram save/reload block
// Assumes: data wire is open drain, resolved by the bench with a pull-up
// Notes:   timing in core cycles: clock low 152 (608 ns), high 104 (416 ns)
`timescale 1ns/1ps
module bus_master_model #(
	parameter int T_LOW  = 152,
	parameter int T_HIGH = 104
) (
	// core clock
	input  wire logic clock_i,
	// resolved wire level and master drives
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_low_o
);
	// idle bus: both lines released
	initial begin
		scl_o     = 1'h1;
		sda_low_o = 1'h0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clock_i);
	endtask
	// one clock pulse; data moves 8 cycles after the fall so a slow
	// filter never sees it change with the clock still high
	task automatic pulse(input logic b, output logic got);
		sda_low_o <= ~b;
		tick(T_LOW);
		scl_o <= 1'h1;
		tick(T_HIGH / 2);
		got = sda_i;
		tick(T_HIGH / 2);
		scl_o <= 1'h0;
		tick(8);
	endtask
	// start or repeated start: data falls with the clock high
	task automatic start();
		sda_low_o <= 1'h0;
		tick(T_LOW);
		scl_o <= 1'h1;
		tick(T_HIGH);
		sda_low_o <= 1'h1;
		tick(T_HIGH);
		scl_o <= 1'h0;
		tick(8);
	endtask
	// clock pulse shorter than the glitch filter, sent while the clock is low
	task automatic spike(input int n);
		scl_o <= 1'h1;
		tick(n);
		scl_o <= 1'h0;
		tick(8);
	endtask
	// stop: data rises with the clock high, then bus free time
	task automatic stop();
		sda_low_o <= 1'h1;
		tick(T_LOW);
		scl_o <= 1'h1;
		tick(T_HIGH);
		sda_low_o <= 1'h0;
		tick(T_HIGH * 2);
	endtask
	// byte out, msb first, then the slave's acknowledge slot
	task automatic send(input logic [7:0] b, output logic ack);
		logic g;
		for (int i = 7; i >= 0; i--) pulse(b[i], g);
		pulse(1'h1, g);
		ack = ~g;
	endtask
	// byte in; more low means no acknowledge, ending the read
	task automatic recv(input logic more, output logic [7:0] b);
		logic g;
		for (int i = 7; i >= 0; i--) pulse(1'h1, b[i]);
		pulse(~more, g);
	endtask
endmodule

// ===== tb/serial_sram_auto_save_control_tb.sv
// Purpose: self-checking bench for the serial sram save/reload control
// Assumes: short save/reload counts so the run stays short
// Notes:   select straps tied to high=1, low=0
`timescale 1ns/1ps
module serial_sram_auto_save_control_tb;
	import sram_save_pkg::*;
	localparam int         SAVE_CYC   = 9000;
	localparam int         RELOAD_CYC = 8500;
	localparam logic [3:0] OPC        = 4'ha;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic clock_i, arst_n_i, scl, sda_wire, sda_o, sda_oe_o, m_low;
	logic wp, trip, busy_o, modified_o;
	int   n_errors, comparisons, cyc_cnt, t0;
	typedef struct {
		ctrl_byte_t ctrl; // control byte sent
		logic       ack;  // acknowledge expected
	} row_t;
	row_t rows [4];
	// pull-up: low whenever either party pulls
	assign sda_wire = ~(sda_oe_o | m_low);
	always @(posedge clock_i) cyc_cnt <= cyc_cnt + 1;
	serial_sram_auto_save_control #(
		.SAVE_CYC(SAVE_CYC), .RELOAD_CYC(RELOAD_CYC), .CTRL_OPCODE(OPC)
	) serial_sram_auto_save_control_inst (
		.clock_i(clock_i), .arst_n_i(arst_n_i), .scl_i(scl), .sda_i(sda_wire),
		.sda_o(sda_o), .sda_oe_o(sda_oe_o), .chip_sel_pin_low_i(1'h0),
		.chip_sel_pin_high_i(1'h1), .write_protect_i(wp), .cap_above_trip_i(trip),
		.busy_o(busy_o), .modified_o(modified_o)
	);
	bus_master_model bus_master_model_inst (
		.clock_i(clock_i), .sda_i(sda_wire), .scl_o(scl), .sda_low_o(m_low)
	);
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic ctrl_byte_t mk(input logic [3:0] op, input logic [1:0] s,
		input logic fx, input logic rd);
		return '{opcode: op, sel: s, fixed: fx, rd: rd};
	endfunction
	task automatic give_verdict();
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk_bit(input logic got, input logic exp, input string what);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: %s got %b want %b", $time, what, got, exp);
		end
	endtask
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask
	// bounded wait for the busy flag; running out ends the run
	task automatic wait_busy(input logic lvl, input int limit);
		int c;
		c = 0;
		while (busy_o !== lvl) begin
			@(posedge clock_i);
			c++;
			if (c > limit) begin
				n_errors++;
				$display("Error at %0t: busy wait timed out", $time);
				give_verdict();
			end
		end
	endtask
	// two-byte write; every byte must be acknowledged, protected or not
	task automatic wr(input logic [12:0] a, input logic [7:0] d0, input logic [7:0] d1);
		logic       ack;
		logic [7:0] seq [5];
		seq = '{mk(OPC, 2'h2, 1'h1, 1'h0), {3'h0, a[12:8]}, a[7:0], d0, d1};
		bus_master_model_inst.start();
		foreach (seq[i]) begin
			bus_master_model_inst.send(seq[i], ack);
			chk_bit(ack, 1'h1, "write byte ack");
		end
		bus_master_model_inst.stop();
	endtask
	// random read of two sequential bytes
	task automatic rd2(input logic [12:0] a, input logic [7:0] e0, input logic [7:0] e1);
		logic       ack;
		logic [7:0] got;
		bus_master_model_inst.start();
		bus_master_model_inst.send(mk(OPC, 2'h2, 1'h1, 1'h0), ack);
		bus_master_model_inst.send({3'h0, a[12:8]}, ack);
		bus_master_model_inst.send(a[7:0], ack);
		bus_master_model_inst.start();
		bus_master_model_inst.send(mk(OPC, 2'h2, 1'h1, 1'h1), ack);
		chk_bit(ack, 1'h1, "read ctrl ack");
		bus_master_model_inst.recv(1'h1, got);
		chk_byte(got, e0, "read byte 0");
		bus_master_model_inst.recv(1'h0, got);
		chk_byte(got, e1, "read byte 1");
		bus_master_model_inst.stop();
	endtask
	// ------------------------------------------------------------
	// clock and sequence
	// ------------------------------------------------------------
	initial begin
		clock_i = 1'h0;
		forever #2 clock_i = ~clock_i;
	end
	initial begin
		logic ack;
		arst_n_i    = 1'h0;
		wp          = 1'h0;
		trip        = 1'h0;
		n_errors    = 0;
		comparisons = 0;
		// select match, wrong straps, fixed bit clear, wrong opcode
		rows[0] = '{mk(OPC, 2'h2, 1'h1, 1'h0), 1'h1};
		rows[1] = '{mk(OPC, 2'h1, 1'h1, 1'h0), 1'h0};
		rows[2] = '{mk(OPC, 2'h2, 1'h0, 1'h0), 1'h0};
		rows[3] = '{mk(4'h5, 2'h2, 1'h1, 1'h0), 1'h0};
		repeat (16) @(posedge clock_i);
		chk_bit(busy_o, 1'h1, "busy in reset");
		chk_bit(modified_o, 1'h0, "modified in reset");
		chk_bit(sda_oe_o, 1'h0, "sda released in reset");
		chk_bit(sda_o, 1'h0, "open-drain level");
		arst_n_i <= 1'h1;
		repeat (4) @(posedge clock_i);
		trip <= 1'h1;
		t0 = cyc_cnt;
		wait_busy(1'h0, 20000);
		chk_bit(cyc_cnt - t0 >= RELOAD_CYC, 1'h1, "power-up reload time");
		foreach (rows[i]) begin
			bus_master_model_inst.start();
			bus_master_model_inst.send(rows[i].ctrl, ack);
			chk_bit(ack, rows[i].ack, "select match");
			bus_master_model_inst.stop();
		end
		// a 48 ns clock spike must not count as a bit
		bus_master_model_inst.start();
		bus_master_model_inst.spike(12);
		bus_master_model_inst.send(rows[0].ctrl, ack);
		chk_bit(ack, 1'h1, "ack after clock spike");
		bus_master_model_inst.stop();
		// straddle the protection boundary, first with protect low
		wr(13'h17ff, 8'h5a, 8'ha5);
		chk_bit(modified_o, 1'h1, "modified after write");
		wp <= 1'h1;
		wr(13'h17ff, 8'h3c, 8'hc3);
		// supply loss with a modified array, poll while busy
		trip <= 1'h0;
		t0 = cyc_cnt;
		wait_busy(1'h1, 8);
		bus_master_model_inst.start();
		bus_master_model_inst.send(mk(OPC, 2'h2, 1'h1, 1'h0), ack);
		chk_bit(ack, 1'h0, "poll during save");
		bus_master_model_inst.stop();
		trip <= 1'h1;
		wait_busy(1'h0, 30000);
		chk_bit(cyc_cnt - t0 >= SAVE_CYC + RELOAD_CYC, 1'h1, "save lockout");
		chk_bit(modified_o, 1'h0, "modified after save");
		// unmodified loss, then loss in mid reload
		trip <= 1'h0;
		wait_busy(1'h1, 8);
		repeat (100) @(posedge clock_i);
		trip <= 1'h1;
		repeat (1000) @(posedge clock_i);
		trip <= 1'h0;
		repeat (100) @(posedge clock_i);
		trip <= 1'h1;
		t0 = cyc_cnt;
		wait_busy(1'h0, 30000);
		chk_bit(cyc_cnt - t0 >= RELOAD_CYC, 1'h1, "reload restarted");
		chk_bit(cyc_cnt - t0 < RELOAD_CYC + 1000, 1'h1, "no save unmodified");
		// data survives save and reload; protect never blocks reads
		rd2(13'h17ff, 8'h3c, 8'ha5);
		give_verdict();
	end
endmodule
